// file: pgpio_ctrl.sv
// Packet-driven five-pin general purpose controller with APB registers
//
// Summary of operation
// R01: Five shared pins, input, output or PWM
// R02: Set-pin: two bytes value, three adds config
// R03: First byte picks pin; 5 and up refused
// R04: Level 0 low, 1-99 PWM, 100 high
// R05: Config byte accepts 0 to 15 only
// R06: Decode three-bit drive mode per output bit
// R07: Function bit hands pin to user control
// R08: Default functions: sense, power, reset, one-wire
// R09: Sample all pins continuously at 32 Hz
// R10: Record rising and falling edges since query
// R11: Read-pin takes index, replies four bytes
// R12: Reply byte 1: level, fall, rise bits
// R13: Reported level is actual sampled pin
// R14: Reply byte 2: requested level as written
// R15: Reply byte 3: function and drive mode
// R16: Acknowledge type is command type with 0x40
// R17: Place-text: column, row, 1-16 characters
// R18: Baud change: acknowledge first, then switch
// R19: Host switches only after acknowledge
// R20: Link starts at 19200 unless boot state differs
// R21: Pin config saved and restored as boot state; the block only restores it from boot_pins and has no save path
// R22: Edge flags clear once reported
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "pgpio_defines.svh"

module pgpio_ctrl
  import pgpio_pkg::*;
#(
  parameter int NPINS      = `PGPIO_NUM_PINS,  // [R01]
  parameter int SAMPLE_CYC = `PGPIO_SAMPLE_CYC,
  parameter int PWM_STEP   = `PGPIO_PWM_STEP_CYC
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // Boot state from storage
  input  wire logic              boot_valid,
  input  wire logic [31:0]       boot_baud,
  input  wire logic [NPINS*12-1:0] boot_pins,
  // Pins: input level, output value, output enable (low drives)
  input  wire logic [NPINS-1:0]  pin_in,
  output logic [NPINS-1:0]       pin_out,
  output logic [NPINS-1:0]       pin_oe_n,
  output logic [NPINS-1:0]       pin_pullup,
  output logic [NPINS-1:0]       pin_pulldown,
  output logic [NPINS-1:0]       pin_slow,
  // Built-in functions when the pin is not user owned; host_power_sense follows pin 1 always
  output logic                   host_power_sense,
  input  wire logic              host_power_drive,
  input  wire logic              host_reset_drive,
  input  wire logic              one_wire_sensor_bus_drive,
  output logic                   one_wire_sensor_bus_in,
  // Baud rate in force on the serial link
  output logic [31:0]            link_baud,
  // Text placement toward the display
  output logic                   text_valid,
  output logic [3:0]             text_col,
  output logic                   text_row,
  output logic [4:0]             text_count
);

  localparam int SW = $clog2(SAMPLE_CYC + 1);
  localparam int PW = $clog2(PWM_STEP + 1);

  // ------------------------------------------------------------------
  // State record
  // ------------------------------------------------------------------
  typedef struct packed {
    pgpio_state_t          st;
    logic [31:0]           cmd;
    logic [31:0]           text;
    logic [31:0]           reply;
    logic [7:0]            ack;
    logic                  busy;
    logic [31:0]           baud;
    logic [31:0]           baud_new;
    logic                  boot_done;
    logic [NPINS*8-1:0]    lvl;
    logic [NPINS*4-1:0]    cfg;
    logic [NPINS-1:0]      smp;
    logic [NPINS-1:0]      rise;
    logic [NPINS-1:0]      fall;
    logic                  primed;
    logic [SW-1:0]         scnt;
    logic [PW-1:0]         pstep;
    logic [6:0]            pphase;
    logic                  pready;
    logic [31:0]           prdata;
    logic                  pslverr;
    logic [NPINS-1:0]      pout;
    logic [NPINS-1:0]      poe_n;
    logic [NPINS-1:0]      pup;
    logic [NPINS-1:0]      pdn;
    logic [NPINS-1:0]      pslow;
    logic                  sense;
    logic                  owire;
    logic                  tvalid;
    logic [3:0]            tcol;
    logic                  trow;
    logic [4:0]            tcount;
  } pgpio_regs_t;

  pgpio_regs_t r_q, r_d;

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    logic       wr;
    logic       rd;
    logic [7:0] ctype;
    logic [7:0] clen;
    logic [7:0] d0;
    logic [7:0] d1;
    logic [7:0] d2;
    logic [2:0] idx;
    logic       ok;
    logic       on;
    logic       want;
    logic [2:0] dm;
    logic       user;
    logic       bdrv;
    logic [7:0] pl;
    wr    = 1'b0;
    rd    = 1'b0;
    ctype = 8'h00;
    clen  = 8'h00;
    d0    = 8'h00;
    d1    = 8'h00;
    d2    = 8'h00;
    idx   = 3'b000;
    ok    = 1'b0;
    on    = 1'b0;
    want  = 1'b0;
    dm    = 3'b000;
    user  = 1'b0;
    bdrv  = 1'b0;
    pl    = 8'h00;
    r_d   = r_q;
    r_d.pready  = 1'b0;
    r_d.pslverr = 1'b0;
    r_d.tvalid  = 1'b0;

    // Boot restore once after reset; the link rate moves here only if boot_valid
    if (!r_q.boot_done) begin
      r_d.boot_done = 1'b1;
      if (boot_valid) begin
        r_d.baud = boot_baud;                                      // [R20]
        r_d.cfg  = '0;
        for (int i = 0; i < NPINS; i++) begin
          r_d.lvl[i*8 +: 8] = boot_pins[i*12 +: 8];                // [R21]
          r_d.cfg[i*4 +: 4] = boot_pins[i*12+8 +: 4];              // [R21]
        end
      end
    end

    // 32 Hz sampler with edge capture; sampling is blind between ticks.
    // The first tick after reset only loads the sample, so a pin that
    // idles high does not report a false rising edge.
    if (r_q.scnt == SW'(SAMPLE_CYC - 1)) begin
      r_d.scnt   = '0;
      r_d.primed = 1'b1;
      r_d.smp    = pin_in;                                         // [R09]
      if (r_q.primed) begin
        r_d.rise = r_q.rise | (pin_in & ~r_q.smp);                 // [R10]
        r_d.fall = r_q.fall | (~pin_in & r_q.smp);                 // [R10]
      end
    end else begin
      r_d.scnt = r_q.scnt + SW'(1);
    end

    // PWM time base: 100 steps per 10 ms period
    if (r_q.pstep == PW'(PWM_STEP - 1)) begin
      r_d.pstep  = '0;
      r_d.pphase = (r_q.pphase == 7'd99) ? 7'd0 : r_q.pphase + 7'd1;
    end else begin
      r_d.pstep = r_q.pstep + PW'(1);
    end

    // APB decode; every access completes after one wait state
    wr = psel && penable && pwrite && !r_q.pready;
    rd = psel && penable && !pwrite && !r_q.pready;
    if (psel && penable && !r_q.pready) begin
      r_d.pready = 1'b1;
      r_d.prdata = 32'h0000_0000;
      unique case (paddr)
        `PGPIO_OFF_CMD: begin
          r_d.prdata = r_q.cmd;
          if (wr && !r_q.busy) begin
            r_d.cmd  = pwdata;
            r_d.busy = 1'b1;
            r_d.st   = PGPIO_ST_EXEC;
          end else if (wr) begin
            r_d.pslverr = 1'b1;
          end
        end
        `PGPIO_OFF_STATUS: r_d.prdata = {23'h0, r_q.busy, r_q.ack};
        `PGPIO_OFF_REPLY:  r_d.prdata = r_q.reply;
        `PGPIO_OFF_BAUD:   r_d.prdata = r_q.baud;
        `PGPIO_OFF_TEXT: begin
          r_d.prdata = r_q.text;
          if (wr) r_d.text = pwdata;
        end
        `PGPIO_OFF_PINS:
          r_d.prdata = {{(32-NPINS){1'b0}}, r_q.smp};
        default: r_d.pslverr = 1'b1;
      endcase
    end

    // Command execution
    ctype = r_q.cmd[`PGPIO_CMD_TYPE_LSB +: 8];
    clen  = r_q.cmd[`PGPIO_CMD_LEN_LSB +: 8];
    d0    = r_q.cmd[`PGPIO_CMD_D0_LSB +: 8];
    d1    = r_q.cmd[`PGPIO_CMD_D1_LSB +: 8];
    d2    = r_q.text[`PGPIO_TEXT_D2_LSB +: 8];
    idx   = d0[2:0];
    unique case (r_q.st)
      PGPIO_ST_IDLE: ;
      PGPIO_ST_EXEC: begin
        r_d.st   = PGPIO_ST_IDLE;
        r_d.busy = 1'b0;
        unique case (ctype)
          `PGPIO_TYPE_SET: begin
            ok = (d0 < 8'(NPINS))                                  // [R03]
              && (d1 <= `PGPIO_LVL_HIGH)                           // [R04]
              && (clen == 8'd2 ||
                  (clen == 8'd3 && d2 <= `PGPIO_FDB_MAX));         // [R02] [R05]
            if (ok) begin
              r_d.lvl[idx*8 +: 8] = d1;                            // [R02]
              if (clen == 8'd3)
                r_d.cfg[idx*4 +: 4] = d2[3:0];                     // [R02]
            end
          end
          `PGPIO_TYPE_READ: begin
            ok = (clen == 8'd1) && (d0 < 8'(NPINS));               // [R11]
            if (ok) begin
              r_d.reply = {4'h0, r_q.cfg[idx*4 +: 4],              // [R15]
                           r_q.lvl[idx*8 +: 8],                    // [R14]
                           5'h00, r_q.rise[idx], r_q.fall[idx],
                           r_q.smp[idx],                           // [R12] [R13]
                           d0};
              // Edges seen on the same tick as the read are kept
              r_d.rise[idx] = r_d.rise[idx] & (r_q.scnt ==         // [R22]
                              SW'(SAMPLE_CYC - 1)) & pin_in[idx] &
                              ~r_q.smp[idx];
              r_d.fall[idx] = r_d.fall[idx] & (r_q.scnt ==         // [R22]
                              SW'(SAMPLE_CYC - 1)) & ~pin_in[idx] &
                              r_q.smp[idx];
            end
          end
          `PGPIO_TYPE_TEXT: begin
            ok = (clen >= `PGPIO_TEXT_MINLEN) &&
                 (clen <= `PGPIO_TEXT_MAXLEN) &&
                 (d0 <= `PGPIO_TEXT_COLS) && (d1 <= `PGPIO_TEXT_ROWS);
            if (ok) begin
              r_d.tvalid = 1'b1;                                   // [R17]
              r_d.tcol   = d0[3:0];
              r_d.trow   = d1[0];
              r_d.tcount = 5'(clen - 8'd2);
            end
          end
          `PGPIO_TYPE_BAUD: begin
            ok = (clen == 8'd4);
            if (ok) begin
              r_d.baud_new = {d2, r_q.text[15:8], d1, d0};
              r_d.busy     = 1'b1;
              r_d.st       = PGPIO_ST_BAUD;                        // [R18]
            end
          end
          default: ok = 1'b0;
        endcase
        r_d.ack = ok ? (ctype | `PGPIO_ACK_FLAG) : `PGPIO_TYPE_NAK; // [R16]
      end
      PGPIO_ST_BAUD: begin
        // Acknowledge has been posted at the old rate; switch now
        r_d.baud = r_q.baud_new;                                   // [R18]
        r_d.busy = 1'b0;
        r_d.st   = PGPIO_ST_IDLE;
      end
      default: r_d.st = PGPIO_ST_IDLE;
    endcase

    // Pin drivers and built-in functions
    for (int i = 0; i < NPINS; i++) begin
      pl   = r_q.lvl[i*8 +: 8];
      dm   = r_q.cfg[i*4 +: 3];
      user = r_q.cfg[i*4 + 3];                                     // [R07]
      on   = (pl >= `PGPIO_LVL_HIGH) ||
             (pl != 8'h00 && {1'b0, r_q.pphase} < pl);             // [R04]
      bdrv = (i == 2) ? host_power_drive :                         // [R08]
             (i == 3) ? host_reset_drive :
             (i == 4) ? one_wire_sensor_bus_drive : 1'b0;
      // Built-in drivers only pull low when not user owned
      want = user ? on : (on && !bdrv);                            // [R07]
      r_d.pout[i]  = want;
      r_d.poe_n[i] = 1'b1;
      r_d.pup[i]   = 1'b0;
      r_d.pdn[i]   = 1'b0;
      r_d.pslow[i] = 1'b0;
      unique case (pgpio_drive_t'(dm))                             // [R06]
        PGPIO_DM_UP_PULLDN: begin
          r_d.poe_n[i] = !want;
          r_d.pdn[i]   = !want;
        end
        PGPIO_DM_STRONG:    r_d.poe_n[i] = 1'b0;
        PGPIO_DM_HIZ:       r_d.poe_n[i] = 1'b1;
        PGPIO_DM_PULLUP_DN: begin
          r_d.poe_n[i] = want;
          r_d.pup[i]   = want;
        end
        PGPIO_DM_SLOW_UP: begin
          r_d.poe_n[i] = !want;
          r_d.pslow[i] = 1'b1;
        end
        PGPIO_DM_SLOW_BOTH: begin
          r_d.poe_n[i] = 1'b0;
          r_d.pslow[i] = 1'b1;
        end
        PGPIO_DM_RESERVED:  r_d.poe_n[i] = 1'b1;
        PGPIO_DM_HIZ_SLOWDN: begin
          r_d.poe_n[i] = want;
          r_d.pslow[i] = 1'b1;
        end
      endcase
      if (!user && bdrv && i >= 2) begin
        r_d.pout[i]  = 1'b0;                                       // [R08]
        r_d.poe_n[i] = 1'b0;
        r_d.pup[i]   = 1'b0;
        r_d.pdn[i]   = 1'b0;
      end
    end
    r_d.sense = r_q.smp[1];                                        // [R08]
    r_d.owire = r_q.cfg[4*4 + 3] ? 1'b1 : pin_in[4];               // [R08]
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r_q          <= '0;
      r_q.st       <= PGPIO_ST_IDLE;
      r_q.baud     <= `PGPIO_BAUD_DEFAULT;                         // [R20]
      r_q.baud_new <= `PGPIO_BAUD_DEFAULT;
      r_q.lvl      <= {NPINS{`PGPIO_LVL_RESET}};
      r_q.cfg      <= {NPINS{`PGPIO_CFG_RESET}};
      r_q.poe_n    <= '1;
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs straight from the state record
  assign pready                 = r_q.pready;
  assign prdata                 = r_q.prdata;
  assign pslverr                = r_q.pslverr;
  assign pin_out                = r_q.pout;
  assign pin_oe_n               = r_q.poe_n;
  assign pin_pullup             = r_q.pup;
  assign pin_pulldown           = r_q.pdn;
  assign pin_slow               = r_q.pslow;
  assign host_power_sense       = r_q.sense;
  assign one_wire_sensor_bus_in = r_q.owire;
  assign link_baud              = r_q.baud;
  assign text_valid             = r_q.tvalid;
  assign text_col               = r_q.tcol;
  assign text_row               = r_q.trow;
  assign text_count             = r_q.tcount;

endmodule : pgpio_ctrl

// file: pgpio_ctrl_sva.sv
// Port assertions for the packet pin controller
`timescale 1ns/1ps
`include "pgpio_defines.svh"

module pgpio_ctrl_sva #(
  parameter int NPINS = 5
) (
  // Clock, reset and bus handshake
  input wire logic             clk,
  input wire logic             rstn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pready,
  input wire logic             pslverr,
  // Boot and pins
  input wire logic             boot_valid,
  input wire logic [NPINS-1:0] pin_in,
  input wire logic [NPINS-1:0] pin_oe_n,
  input wire logic [NPINS-1:0] pin_pullup,
  input wire logic [NPINS-1:0] pin_pulldown,
  input wire logic             one_wire_sensor_bus_in,
  // Link and text
  input wire logic [31:0]      link_baud,
  input wire logic             text_valid,
  input wire logic [4:0]       text_count
);
  // -----------------------------------------------
  // Checks
  // -----------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_ready_follows: assert property (psel && penable && !pready |=> pready)
    else $error("pready did not follow the access phase");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr seen without pready");
  a_wire_follows: assert property ($past(rstn) && !one_wire_sensor_bus_in
    |-> !$past(pin_in[4]))
    else $error("one-wire input low while pad was high");
  a_pull_excl: assert property ((pin_pullup & pin_pulldown) == '0)
    else $error("pull-up and pull-down both on");
  a_pull_undriven: assert property (((pin_pullup | pin_pulldown) & ~pin_oe_n)
    == '0)
    else $error("resistive pull while pad is driven");
  a_text_count: assert property (text_valid |-> text_count inside {[1:16]})
    else $error("text count out of range");
  a_text_pulse: assert property (text_valid |=> !text_valid)
    else $error("text strobe longer than one cycle");
  a_baud_default: assert property (!$past(rstn) && !boot_valid
    |=> link_baud == `PGPIO_BAUD_DEFAULT)
    else $error("link rate not default after reset");
endmodule : pgpio_ctrl_sva

bind pgpio_ctrl pgpio_ctrl_sva #(.NPINS(NPINS)) pgpio_ctrl_sva_i (
  .clk, .rstn, .psel, .penable, .pready, .pslverr, .boot_valid, .pin_in,
  .pin_oe_n, .pin_pullup, .pin_pulldown, .one_wire_sensor_bus_in,
  .link_baud, .text_valid, .text_count
);

// file: pgpio_defines.svh
// Offsets, field positions, reset values and timing counts for the pin block
`ifndef PGPIO_DEFINES_SVH
`define PGPIO_DEFINES_SVH

// APB register offsets (byte addresses)
`define PGPIO_OFF_CMD      12'h000
`define PGPIO_OFF_STATUS   12'h004
`define PGPIO_OFF_REPLY    12'h008
`define PGPIO_OFF_BAUD     12'h00C
`define PGPIO_OFF_TEXT     12'h010
`define PGPIO_OFF_PINS     12'h014

// CMD register fields
`define PGPIO_CMD_TYPE_LSB 0
`define PGPIO_CMD_LEN_LSB  8
`define PGPIO_CMD_D0_LSB   16
`define PGPIO_CMD_D1_LSB   24
`define PGPIO_TEXT_D2_LSB  0

// Command types and acknowledge flag
`define PGPIO_TYPE_TEXT    8'h1F
`define PGPIO_TYPE_BAUD    8'h21
`define PGPIO_TYPE_SET     8'h22
`define PGPIO_TYPE_READ    8'h23
`define PGPIO_ACK_FLAG     8'h40
`define PGPIO_TYPE_NAK     8'hC0

// Value ranges
`define PGPIO_NUM_PINS     5
`define PGPIO_LVL_HIGH     8'h64
`define PGPIO_FDB_MAX      8'h0F
`define PGPIO_TEXT_COLS    8'h0F
`define PGPIO_TEXT_ROWS    8'h01
`define PGPIO_TEXT_MINLEN  8'h03
`define PGPIO_TEXT_MAXLEN  8'h12

// Reset values
`define PGPIO_BAUD_DEFAULT 32'd19200
`define PGPIO_LVL_RESET    8'h00
`define PGPIO_CFG_RESET    4'h2

// Timing: 100 MHz clock, 100 Hz PWM of 100 steps, 32 Hz sampling
`define PGPIO_CLK_HZ       100000000
`define PGPIO_PWM_HZ       100
`define PGPIO_SAMPLE_HZ    32
`define PGPIO_PWM_STEP_CYC (`PGPIO_CLK_HZ / (`PGPIO_PWM_HZ * 100))
`define PGPIO_SAMPLE_CYC   (`PGPIO_CLK_HZ / `PGPIO_SAMPLE_HZ)

`endif

// file: pgpio_pin_load.sv
// Pad model: resolves each pin from the design and an outside driver
`timescale 1ns/1ps

module pgpio_pin_load (
  // Clock
  input wire logic       clk,
  // Design side of each pad
  input wire logic [4:0] pin_out,
  input wire logic [4:0] pin_oe_n,
  input wire logic [4:0] pin_pullup,
  input wire logic [4:0] pin_pulldown,
  // Outside driver
  input wire logic [4:0] ext_en,
  input wire logic [4:0] ext_val,
  // Resolved level
  output logic [4:0]     pad
);
  logic [4:0] last_q = 5'h00;
  // A floating pad toggles, except pin 4 which floats high, so a stale level never passes for a real one
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (!pin_oe_n[i]) pad[i] = pin_out[i];
      else if (ext_en[i]) pad[i] = ext_val[i];
      else if (pin_pullup[i] || i == 4) pad[i] = 1'b1;
      else if (pin_pulldown[i]) pad[i] = 1'b0;
      else pad[i] = ~last_q[i];
    end
  end
  // Last level seen
  always_ff @(posedge clk) last_q <= pad;
endmodule : pgpio_pin_load

// file: pgpio_pkg.sv
// Types shared by the packet pin controller
package pgpio_pkg;

  // Drive mode codes, in the layout of the function_drive_byte
  typedef enum logic [2:0] {
    PGPIO_DM_UP_PULLDN = 3'b000,
    PGPIO_DM_STRONG    = 3'b001,
    PGPIO_DM_HIZ       = 3'b010,
    PGPIO_DM_PULLUP_DN = 3'b011,
    PGPIO_DM_SLOW_UP   = 3'b100,
    PGPIO_DM_SLOW_BOTH = 3'b101,
    PGPIO_DM_RESERVED  = 3'b110,
    PGPIO_DM_HIZ_SLOWDN = 3'b111
  } pgpio_drive_t;

  // Command engine states, one-hot
  typedef enum logic [2:0] {
    PGPIO_ST_IDLE = 3'b001,
    PGPIO_ST_EXEC = 3'b010,
    PGPIO_ST_BAUD = 3'b100
  } pgpio_state_t;

endpackage : pgpio_pkg

// file: test_pgpio_ctrl.sv
// Self-checking bench for the packet pin controller
`timescale 1ns/1ps
`include "pgpio_defines.svh"

module test_pgpio_ctrl;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, bv;
  logic        sense, hpd, hrd, owd, ow_in, tv, trow, lerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, bb, baud, r;
  logic [59:0] bp;
  logic [4:0]  pin_in, po, poe, pu, pd, ps, een, ev, tcnt_o;
  logic [3:0]  tcol;
  logic [7:0]  ack;
  logic [9:0]  tcap;
  int          mismatches, samples_checked, tn, hi;
  // Expected {oe_n, pull-up, pull-down, slow} per {level bit, drive mode}
  localparam logic [63:0] dtab = 64'h9811_C800_1819_080A;

  // Short counts keep the run brief
  pgpio_ctrl #(.SAMPLE_CYC(20), .PWM_STEP(2)) pgpio_ctrl_i (
    .clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .boot_valid(bv), .boot_baud(bb), .boot_pins(bp),
    .pin_in, .pin_out(po), .pin_oe_n(poe), .pin_pullup(pu),
    .pin_pulldown(pd), .pin_slow(ps), .host_power_sense(sense),
    .host_power_drive(hpd), .host_reset_drive(hrd),
    .one_wire_sensor_bus_drive(owd), .one_wire_sensor_bus_in(ow_in),
    .link_baud(baud), .text_valid(tv), .text_col(tcol), .text_row(trow),
    .text_count(tcnt_o));
  pgpio_pin_load pgpio_pin_load_i (.clk, .pin_out(po), .pin_oe_n(poe),
    .pin_pullup(pu), .pin_pulldown(pd), .ext_en(een), .ext_val(ev),
    .pad(pin_in));

  always #5 clk = ~clk;
  // Text strobes are caught here since they last one cycle
  always @(posedge clk) if (tv === 1'b1) begin
    tcap <= {tcol, trow, tcnt_o};
    tn <= tn + 1;
  end

  task automatic stop_test;
    $display("compared %0d mismatched %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk("pready", 1, 0);
      stop_test();
    end
    r = prdata;
    lerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Issue a command and poll until the engine is idle
  task automatic cmd(input logic [7:0] t, l, b0, b1, b2);
    int n;
    apb(1, `PGPIO_OFF_TEXT, {24'h00_0000, b2});
    apb(1, `PGPIO_OFF_CMD, {b1, b0, l, t});
    n = 0;
    do begin
      apb(0, `PGPIO_OFF_STATUS, 0);
      n++;
    end while (r[8] !== 1'b0 && n < 10);
    if (r[8] !== 1'b0) begin
      chk("busy", 0, 1);
      stop_test();
    end
    ack = r[7:0];
  endtask : cmd

  task automatic rp(input logic [7:0] i);
    cmd(8'h23, 8'h01, i, 8'h00, 8'h00);
    chk("read ack", 8'h63, ack);
    apb(0, `PGPIO_OFF_REPLY, 0);
  endtask : rp

  task automatic setp(input logic [7:0] i, v, c);
    cmd(8'h22, 8'h03, i, v, c);
    chk("set ack", 8'h62, ack);
  endtask : setp

  initial begin
    {clk, rstn, psel, penable, pwrite, bv, hpd, hrd, owd} = '0;
    {paddr, pwdata, bb, bp, een, ev, tn, tcap} = '0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    apb(0, `PGPIO_OFF_BAUD, 0);
    chk("baud", 32'd19200, r);
    rp(8'h00);
    chk("reset level cfg", 12'h200, r[27:16]);
    // Drive mode table: oe_n, pulls and slow per mode for output 1 and output 0
    for (int k = 0; k < 16; k++) begin
      setp(8'h00, (k[0] ? 8'h64 : 8'h00), 8'h08 | k[3:1]);
      chk("drive", dtab[{k[0], k[3:1]} * 4 +: 4],
          {poe[0], pu[0], pd[0], ps[0]});
    end
    // Duty over one PWM period of 100 steps of 2 cycles
    for (int v = 0; v <= 100; v += 33) begin
      setp(8'h00, v[7:0] + (v == 99), 8'h09);
      hi = 0;
      repeat (200) @(posedge clk) hi += po[0];
      chk("duty", 2 * (v + (v == 99)), hi);
    end
    cmd(8'h22, 8'h02, 8'h00, 8'h32, 8'h00);
    chk("value only", 8'h62, ack);
    rp(8'h00);
    chk("reply", 20'h9_3200, {r[27:16], r[7:0]});
    // Refused commands leave the pin alone
    cmd(8'h22, 8'h03, 8'h05, 8'h00, 8'h02);
    chk("bad index", 8'hC0, ack);
    cmd(8'h22, 8'h02, 8'h00, 8'h65, 8'h00);
    chk("bad level", 8'hC0, ack);
    cmd(8'h22, 8'h03, 8'h00, 8'h00, 8'h10);
    chk("bad cfg", 8'hC0, ack);
    rp(8'h00);
    chk("unchanged", 12'h932, r[27:16]);
    // Edges on an input pad, then cleared once reported
    setp(8'h00, 8'h00, 8'h02);
    een <= 5'h03;
    repeat (60) @(posedge clk);
    rp(8'h00);
    ev <= 5'h03;
    repeat (60) @(posedge clk);
    chk("sense high", 1, sense);
    ev <= 5'h00;
    repeat (60) @(posedge clk);
    chk("sense low", 0, sense);
    rp(8'h00);
    chk("edges", 8'h06, r[15:8]);
    rp(8'h00);
    chk("cleared", 8'h00, r[15:8]);
    // Built-in power drive, then handed to the user
    {hpd, hrd, owd} <= 3'b111;
    repeat (3) @(posedge clk);
    chk("builtin", 7'h00, {poe[4:2], po[4:2], ow_in});
    setp(8'h02, 8'h00, 8'h0A);
    chk("user owned", 1, poe[2]);
    {hpd, hrd, owd} <= 3'b000;
    // Text placement and its limits
    cmd(8'h1F, 8'h05, 8'h0F, 8'h01, 8'h41);
    chk("text ack", 8'h5F, ack);
    cmd(8'h1F, 8'h05, 8'h00, 8'h02, 8'h41);
    chk("bad row", 8'hC0, ack);
    cmd(8'h1F, 8'h02, 8'h00, 8'h00, 8'h41);
    chk("short text", 8'hC0, ack);
    chk("text", {4'hF, 1'b1, 5'd3, 22'd1}, {tcap, tn[21:0]});
    chk("one-wire idle", 1, ow_in);
    // Baud change, then an unmapped address
    cmd(8'h21, 8'h04, 8'h80, 8'h25, 8'h00);
    chk("baud ack", 8'h61, ack);
    apb(0, `PGPIO_OFF_BAUD, 0);
    chk("new baud", 32'h0000_2580, r);
    apb(0, 12'h018, 0);
    chk("unmapped err", 1, lerr);
    chk("unmapped data", 32'h0000_0000, r);
    // Boot state restored by a second reset
    rstn <= 1'b0;
    bv <= 1'b1;
    bb <= 32'h0000_9600;
    bp[11:0] <= 12'h964;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    chk("boot baud", 32'h0000_9600, baud);
    chk("boot pin", 2'b01, {poe[0], po[0]});
    stop_test();
  end
endmodule : test_pgpio_ctrl
